// ===== common/remap_cfg.svh
// offsets, field positions, reset values and limits of the remap and error-count registers
`ifndef REMAP_CFG_SVH
`define REMAP_CFG_SVH
`define RMP_OFS_CTRL        8'h04
`define RMP_OFS_REAL        8'h07
`define RMP_OFS_ALIAS       8'h08
`define RMP_OFS_ERR_LO      8'h0a
`define RMP_OFS_ERR_HI      8'h0b
`define RMP_CRC_RESET_BIT   5
`define RMP_ADDR_MSB        7
`define RMP_ADDR_LSB        1
`define RMP_ADDR_RST        7'h00
`define RMP_ERR_RST         16'h0000
`define RMP_ERR_MAX         16'hffff
`define RMP_ERR_ONE         16'h0001
`define RMP_RDATA_RST       8'h00
`endif

// ===== common/remap_pkg.sv
// types shared by the remap register slice and its error counter
package remap_pkg;
  typedef logic [6:0]  addr7_t;
  typedef logic [15:0] err_count_t;

  typedef struct packed {
    err_count_t count;
  } err_state_s;

  typedef struct packed {
    logic [1:0][6:0] real_addr;
    logic [1:0][6:0] alias_addr;
    logic            crc_reset;
    logic [1:0]      link_lost;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            fwd_valid;
    addr7_t          fwd_addr;
    logic            fwd_blocked;
  } remap_state_s;
endpackage

// ===== src/bc_error_counter.sv
// saturating counter of back-channel crc errors for one link port
`timescale 1ns/100ps
`include "remap_cfg.svh"
module bc_error_counter (
  // clock, reset and enable
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // control and event
  input  wire logic                  clr,
  input  wire logic                  inc,
  // count
  output remap_pkg::err_count_t      count
);
  remap_pkg::err_state_s st_r;
  remap_pkg::err_state_s st_nxt;

  function automatic remap_pkg::err_count_t sat_inc(input remap_pkg::err_count_t v);
    sat_inc = (v == `RMP_ERR_MAX) ? v : v + `RMP_ERR_ONE; // RULE8
  endfunction

  always_comb begin
    st_nxt = st_r;
    // an error landing on the clear cycle still counts, but clr held high into the next cycle wipes it again
    if (clr) begin
      st_nxt.count = inc ? `RMP_ERR_ONE : `RMP_ERR_RST; // RULE5
    end else if (inc) begin
      st_nxt.count = sat_inc(st_r.count); // RULE4
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.count <= `RMP_ERR_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;

  err_saturate_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    ce && !clr && st_r.count == `RMP_ERR_MAX |=> st_r.count == `RMP_ERR_MAX)
    else $error("error count wrapped past its maximum");
endmodule

// ===== src/remote_target_remap.sv
// remote target alias remap table and back-channel crc error counters for two link ports
`timescale 1ns/100ps
`include "remap_cfg.svh"
// Behaviour
// RULE1 - a transaction to the alias address is forwarded with the real address instead
// RULE2 - a zero real or alias address blocks every access to that remote target
// RULE3 - alias and real address registers keep seven bits in 7:1, bit 0 reserved
// RULE4 - back-channel crc errors counted in sixteen read-only bits, low 0x0a, high 0x0b
// RULE5 - setting bit 5 of register 0x04 clears both counter bytes
// RULE6 - second-port select steers register accesses to the second port's copies
// RULE7 - the same bit 5 also clears the sticky link-lost flag
// RULE8 - the error counter saturates at its maximum instead of wrapping
module remote_target_remap (
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // register access
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  // port view
  input  wire logic                  second_port_view_select,
  // i2c transaction from the local master
  input  wire logic                  txn_valid,
  input  wire logic                  txn_port,
  input  wire remap_pkg::addr7_t     txn_addr,
  // transaction toward the control channel
  output logic                       fwd_valid,
  output remap_pkg::addr7_t          fwd_addr,
  output logic                       fwd_blocked,
  // link events per port
  input  wire logic [1:0]            crc_err,
  input  wire logic [1:0]            link_loss,
  output logic [1:0]                 link_lost_flag
);
  remap_pkg::remap_state_s st_r;
  remap_pkg::remap_state_s st_nxt;
  remap_pkg::err_count_t   err_count [2];
  logic                    sel;

  // a zero in either field disables the target outright
  function automatic logic target_enabled(input remap_pkg::addr7_t real_a,
                                          input remap_pkg::addr7_t alias_a);
    target_enabled = (real_a != `RMP_ADDR_RST) && (alias_a != `RMP_ADDR_RST);
  endfunction

  function automatic logic alias_match(input remap_pkg::addr7_t a,
                                       input remap_pkg::addr7_t alias_a);
    alias_match = (alias_a != `RMP_ADDR_RST) && (a == alias_a);
  endfunction

  assign sel = second_port_view_select;

  for (genvar p = 0; p < 2; p++) begin : g_cnt
    bc_error_counter u_cnt (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .clr   (st_r.crc_reset),
      .inc   (crc_err[p]),
      .count (err_count[p])
    );
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.fwd_valid = 1'b0;
    st_nxt.fwd_blocked = 1'b0;
    // real and alias writes land in the copy of the selected port; the control bit is shared
    if (reg_wr) begin
      unique case (reg_addr)
        `RMP_OFS_CTRL: st_nxt.crc_reset = reg_wdata[`RMP_CRC_RESET_BIT]; // RULE5
        `RMP_OFS_REAL: st_nxt.real_addr[sel] = reg_wdata[`RMP_ADDR_MSB:`RMP_ADDR_LSB]; // RULE3 RULE6
        `RMP_OFS_ALIAS: st_nxt.alias_addr[sel] = reg_wdata[`RMP_ADDR_MSB:`RMP_ADDR_LSB]; // RULE3 RULE6
        default: ;
      endcase
    end
    // reads answer one cycle later; unmapped offsets read zero
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      unique case (reg_addr)
        `RMP_OFS_CTRL: st_nxt.rdata = {2'b00, st_r.crc_reset, 5'b0_0000};
        `RMP_OFS_REAL: st_nxt.rdata = {st_r.real_addr[sel], 1'b0}; // RULE3 RULE6
        `RMP_OFS_ALIAS: st_nxt.rdata = {st_r.alias_addr[sel], 1'b0}; // RULE3 RULE6
        `RMP_OFS_ERR_LO: st_nxt.rdata = err_count[sel][7:0]; // RULE4 RULE6
        `RMP_OFS_ERR_HI: st_nxt.rdata = err_count[sel][15:8]; // RULE4 RULE6
        default: st_nxt.rdata = `RMP_RDATA_RST;
      endcase
    end
    // sticky link-lost: a loss on the clearing cycle still sets the flag
    for (int p = 0; p < 2; p++) begin
      if (link_loss[p]) begin
        st_nxt.link_lost[p] = 1'b1;
      end else if (st_r.crc_reset) begin
        st_nxt.link_lost[p] = 1'b0; // RULE7
      end
    end
    // only a transaction that hits an alias is this block's to forward
    if (txn_valid && alias_match(txn_addr, st_r.alias_addr[txn_port])) begin
      if (target_enabled(st_r.real_addr[txn_port], st_r.alias_addr[txn_port])) begin
        st_nxt.fwd_valid = 1'b1;
        st_nxt.fwd_addr = st_r.real_addr[txn_port]; // RULE1
      end else begin
        st_nxt.fwd_blocked = 1'b1; // RULE2
      end
    end else if (txn_valid && st_r.alias_addr[txn_port] == `RMP_ADDR_RST) begin
      st_nxt.fwd_blocked = 1'b1; // RULE2
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.real_addr <= {2{`RMP_ADDR_RST}};
      st_r.alias_addr <= {2{`RMP_ADDR_RST}};
      st_r.crc_reset <= 1'b0;
      st_r.link_lost <= 2'b00;
      st_r.rdata <= `RMP_RDATA_RST;
      st_r.rvalid <= 1'b0;
      st_r.fwd_valid <= 1'b0;
      st_r.fwd_addr <= `RMP_ADDR_RST;
      st_r.fwd_blocked <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign fwd_valid = st_r.fwd_valid;
  assign fwd_addr = st_r.fwd_addr;
  assign fwd_blocked = st_r.fwd_blocked;
  assign link_lost_flag = st_r.link_lost;

  remap_forward_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    ce && txn_valid && alias_match(txn_addr, st_r.alias_addr[txn_port])
    && st_r.real_addr[txn_port] != `RMP_ADDR_RST
    |=> fwd_valid && !fwd_blocked && fwd_addr == $past(st_r.real_addr[txn_port]))
    else $error("aliased transaction not forwarded with real address");

  zero_blocks_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    ce && txn_valid && (st_r.real_addr[txn_port] == `RMP_ADDR_RST
    || st_r.alias_addr[txn_port] == `RMP_ADDR_RST) |=> !fwd_valid)
    else $error("transaction forwarded to a disabled target");

  reserved_bit_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    ce && reg_rd && (reg_addr == `RMP_OFS_REAL || reg_addr == `RMP_OFS_ALIAS)
    |=> reg_rvalid && reg_rdata[0] == 1'b0)
    else $error("reserved address bit read as one");

  err_read_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    ce && reg_rd && reg_addr == `RMP_OFS_ERR_HI
    |=> reg_rdata == $past(err_count[sel][15:8]))
    else $error("error count high byte read wrong");

  err_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    ce && st_r.crc_reset && crc_err == 2'b00
    |=> err_count[0] == `RMP_ERR_RST && err_count[1] == `RMP_ERR_RST)
    else $error("error counters not cleared by crc reset");

  port_view_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    ce && reg_wr && reg_addr == `RMP_OFS_ALIAS ##1 ce && !reg_wr
    ##1 ce && reg_rd && reg_addr == `RMP_OFS_ALIAS && !reg_wr && sel == $past(sel, 2)
    |=> reg_rdata[`RMP_ADDR_MSB:`RMP_ADDR_LSB] == $past(reg_wdata[`RMP_ADDR_MSB:`RMP_ADDR_LSB], 3))
    else $error("alias write not visible in the same port view");

  link_lost_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    ce && st_r.crc_reset && link_loss == 2'b00 |=> link_lost_flag == 2'b00)
    else $error("link-lost flag survived crc reset");

  link_lost_sticky_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    ce && !st_r.crc_reset |=> (link_lost_flag & $past(link_lost_flag)) == $past(link_lost_flag))
    else $error("link-lost flag dropped without crc reset");

  no_match_quiet_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    ce && txn_valid && st_r.alias_addr[txn_port] != `RMP_ADDR_RST && txn_addr != st_r.alias_addr[txn_port]
    |=> !fwd_valid && !fwd_blocked)
    else $error("transaction to a foreign address was answered");

  real_write_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    ce && reg_wr && reg_addr == `RMP_OFS_REAL
    |=> st_r.real_addr[$past(sel)] == $past(reg_wdata[`RMP_ADDR_MSB:`RMP_ADDR_LSB]))
    else $error("real address write did not keep the address field");

  other_port_kept_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    ce && reg_wr && reg_addr == `RMP_OFS_ALIAS
    |=> st_r.alias_addr[~$past(sel)] == $past(st_r.alias_addr[~sel]))
    else $error("alias write leaked into the unselected port");

  err_low_read_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    ce && reg_rd && reg_addr == `RMP_OFS_ERR_LO
    |=> reg_rvalid && reg_rdata == $past(err_count[sel][7:0]))
    else $error("error count low byte read wrong");

  count_read_only_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    ce && reg_wr && (reg_addr == `RMP_OFS_ERR_LO || reg_addr == `RMP_OFS_ERR_HI)
    && !st_r.crc_reset && crc_err == 2'b00
    |=> err_count[0] == $past(err_count[0]) && err_count[1] == $past(err_count[1]))
    else $error("write changed a read-only error count");

  rvalid_pulse_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    ce && !reg_rd
    |=> !reg_rvalid)
    else $error("read answer without a read");

  crc_reset_write_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    ce && reg_wr && reg_addr == `RMP_OFS_CTRL
    |=> st_r.crc_reset == $past(reg_wdata[`RMP_CRC_RESET_BIT]))
    else $error("crc reset bit not taken from the control write");

  ctrl_read_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    ce && reg_rd && reg_addr == `RMP_OFS_CTRL
    |=> reg_rdata[`RMP_CRC_RESET_BIT] == $past(st_r.crc_reset))
    else $error("crc reset bit read back wrong");

  link_lost_set_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    ce && link_loss != 2'b00
    |=> (link_lost_flag & $past(link_loss)) == $past(link_loss))
    else $error("link loss did not set its flag");
endmodule

// ===== verif/far_side_model.sv
// far side model: link event source and observer of forwarded transactions
`timescale 1ns/100ps
module far_side_model (
  // clock
  input  wire logic              clk,
  // control channel side
  input  wire logic              fwd_valid,
  input  wire remap_pkg::addr7_t fwd_addr,
  input  wire logic              fwd_blocked,
  // link events
  output logic [1:0]             crc_err,
  output logic [1:0]             link_loss
);
  int n_fwd;
  int n_blk;
  initial begin
    crc_err = 2'b00;
    link_loss = 2'b00;
    n_fwd = 0;
    n_blk = 0;
  end
  always @(posedge clk) begin
    if (fwd_valid === 1'b1) n_fwd++;
    if (fwd_blocked === 1'b1) n_blk++;
  end
  // events held for whole cycles, one event counted per cycle high
  task pulse(input logic [1:0] c, input logic [1:0] l, input int cycles);
    @(posedge clk);
    #1 crc_err = c;
    link_loss = l;
    repeat (cycles) @(posedge clk);
    #1 crc_err = 2'b00;
    link_loss = 2'b00;
  endtask
endmodule

// ===== verif/test_remote_target_remap.sv
// self-checking testbench of the remap table and error counters
`timescale 1ns/100ps
module test_remote_target_remap;
  logic              clk, rst, ce, reg_wr, reg_rd, sel, txn_valid, txn_port, reg_rvalid, fwd_valid, fwd_blocked;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, d, n;
  remap_pkg::addr7_t txn_addr, fwd_addr;
  logic [1:0]        crc_err, link_loss, link_lost_flag;
  logic [7:0]        al [2];
  logic [7:0]        re [2];
  logic [7:0]        ofs [4] = '{8'h07, 8'h08, 8'h0a, 8'h0b};
  int                n_fail, total_checks, seed;
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  remote_target_remap u_dut (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .second_port_view_select(sel), .txn_valid(txn_valid), .txn_port(txn_port), .txn_addr(txn_addr),
    .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_blocked(fwd_blocked), .crc_err(crc_err),
    .link_loss(link_loss), .link_lost_flag(link_lost_flag));
  far_side_model u_far (.clk(clk), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_blocked(fwd_blocked),
    .crc_err(crc_err), .link_loss(link_loss));
  function logic [7:0] field(input logic [7:0] w);
    return {w[7:1], 1'b0};
  endfunction
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    #1 reg_wr = 1;
    reg_addr = a;
    reg_wdata = w;
    @(posedge clk);
    #1 reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_rd = 1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 0;
    chk("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
    chk("rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // exp holds blocked then valid
  task txn(input logic p, input remap_pkg::addr7_t a, input logic [1:0] exp);
    @(posedge clk);
    #1 txn_valid = 1;
    txn_port = p;
    txn_addr = a;
    @(posedge clk);
    #1 txn_valid = 0;
    chk("fwd", {14'h0000, fwd_blocked, fwd_valid}, {14'h0000, exp});
  endtask
  task test_done;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(8 * 90000);
    n_fail++;
    test_done;
  end
  initial begin
    seed = 56222;
    {rst, reg_wr, reg_rd, sel, txn_valid, txn_port} = 6'b100000;
    ce = 1;
    {reg_addr, reg_wdata, txn_addr} = 23'h00_0000;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    for (int p = 0; p < 2; p++) begin
      sel = p[0];
      foreach (ofs[i]) rd(ofs[i], 8'h00);
      re[p] = 8'($random(seed)) | 8'h03;
      al[p] = 8'($random(seed)) | 8'h03;
      wr(8'h07, re[p]);
      wr(8'h08, al[p]);
    end
    for (int p = 0; p < 2; p++) begin
      sel = p[0];
      rd(8'h07, field(re[p]));
      rd(8'h08, field(al[p]));
      txn(p[0], al[p][7:1], 2'b01);
      chk("fwd_addr", {9'h000, fwd_addr}, {9'h000, re[p][7:1]});
      txn(p[0], al[p][7:1] ^ 7'h40, 2'b00);
    end
    sel = 0;
    wr(8'h07, 8'h00);
    txn(0, al[0][7:1], 2'b10);
    sel = 1;
    wr(8'h08, 8'h00);
    txn(1, 7'h11, 2'b10);
    n = (8'($random(seed)) & 8'h0f) + 8'h01;
    u_far.pulse(2'b10, 2'b01, n);
    wr(8'h0a, 8'hff);
    rd(8'h0a, n);
    rd(8'h0b, 8'h00);
    sel = 0;
    rd(8'h0a, 8'h00);
    chk("link_lost", {14'h0000, link_lost_flag}, 16'h0001);
    wr(8'h04, 8'h20);
    repeat (2) @(posedge clk);
    #1;
    chk("link_lost", {14'h0000, link_lost_flag}, 16'h0000);
    sel = 1;
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    rd(8'h04, 8'h20);
    wr(8'h04, 8'h00);
    // with the enable low nothing may move: events and writes are both dropped
    ce = 0;
    u_far.pulse(2'b10, 2'b10, 4);
    wr(8'h08, 8'h54);
    ce = 1;
    rd(8'h0a, 8'h00);
    chk("link_lost", {14'h0000, link_lost_flag}, 16'h0000);
    wr(8'h08, 8'h55);
    rd(8'h08, 8'h54);
    sel = 0;
    rd(8'h08, field(al[0]));
    // long burst past full scale shows the count pinned, not wrapped
    u_far.pulse(2'b01, 2'b00, 65540);
    sel = 0;
    rd(8'h0a, 8'hff);
    rd(8'h0b, 8'hff);
    chk("forwards", u_far.n_fwd[15:0], 16'h0002);
    chk("blocks", u_far.n_blk[15:0], 16'h0002);
    // a second reset mid-run must bring back the cleared state
    rst = 1;
    @(posedge clk);
    #1 rst = 0;
    rd(8'h0a, 8'h00);
    rd(8'h08, 8'h00);
    chk("link_lost", {14'h0000, link_lost_flag}, 16'h0000);
    test_done;
  end
endmodule
